// *** verilog/rstc_reset_controller.sv ***
/*
 * Reset controller: gathers reset sources, records the cause, sequences
 * hold, initialization, start-up delay and memory scan, and drives the
 * domain resets. APB slave for cause, software reset and unlock registers.
 * Assumes detector and pin inputs are asynchronous and are synchronised
 * here; the fuse loader presents stable fuse values.
 */
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps

// Behaviour
// - Program counter restarts at zero after reset
// - Cause register records the reset source
// - Power-on held through start-up and initialization
// - Supply loss reasserts reset at once
// - Brown-out held until supply recovers
// - Pin filter rejects short low pulses
// - Pin acts only when fuse enables
// - Pin holds reset while low
// - Watchdog reset follows after about 150 ns
// - Software trigger starts reset in about 150 ns
// - Debug reset only from debug port
// - High-voltage edges on pin cause reset
// - Supply resets clear brown-out config, debug port
// - User resets spare brown-out config, debug port
// - High-voltage resets debug port, not brown-out config
// - Hold while sources active, then initialize
// - Supply cause adds fuse start-up delay
// - Fuse-selected memory scan lengthens initialization
// - Controller always active in all modes
// - Software reset needs unlock within four instructions
// - Brown-out, pin, watchdog need enables
// - Cause flags bits 0-5, write one clears
// - Trigger bit 0 always reads zero
module rstc_reset_controller
    import rstc_pkg::*;
#(
    parameter int PIN_FILT_CYC = RSTC_PIN_FILT_CYC,
    parameter int INIT_CYC = RSTC_INIT_CYC,
    parameter int STARTUP_UNIT_CYC = 8192
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_low,
    input wire logic bod_low,
    input wire logic bod_enable,
    input wire logic reset_pin,
    input wire logic reset_pin_enable_fuse,
    input wire logic hv_present,
    input wire logic wdt_timeout,
    input wire logic wdt_enable,
    input wire logic program_debug_port_reset,
    input wire logic [2:0] startup_delay_select,
    input wire logic boot_crc_scan_select,
    input wire logic crc_scan_done,
    input wire logic cpu_insn_retire,
    output logic sys_rst_b_ff,
    output logic bod_cfg_rst_b_ff,
    output logic debug_port_rst_b_ff,
    output logic fuse_reload_ff,
    output logic crc_scan_start_ff,
    output logic [31:0] pc_reset_value_ff
);

    // Two-flop synchronisers for all asynchronous inputs
    logic [5:0] sync1_ff, sync2_ff;
    logic [5:0] async_in;
    assign async_in = {por_low, bod_low, reset_pin, hv_present, wdt_timeout, program_debug_port_reset};
    always_ff @(posedge mclk) begin
        sync1_ff <= async_in;
        sync2_ff <= sync1_ff;
    end
    logic s_por, s_bod, s_pin, s_hv, s_wdt, s_dbg;
    assign {s_por, s_bod, s_pin, s_hv, s_wdt, s_dbg} = sync2_ff;

    // Source state: filter, delays, edge history
    logic [15:0] filt_cnt_ff, nxt_filt_cnt;
    logic pin_req_ff, nxt_pin_req;
    logic hv_prev_ff, nxt_hv_prev;
    logic hv_req_ff, nxt_hv_req;
    logic wdt_prev_ff, nxt_wdt_prev;
    logic [4:0] wdt_dly_ff, nxt_wdt_dly;
    logic [4:0] sw_dly_ff, nxt_sw_dly;
    logic wdt_req, sw_req, sw_fire, bod_req;

    always_comb begin
        nxt_filt_cnt = filt_cnt_ff;
        nxt_pin_req = pin_req_ff;
        // Pin low must persist before a request is raised
        if (!reset_pin_enable_fuse || s_pin) begin
            nxt_filt_cnt = 16'h0000;
            nxt_pin_req = 1'b0;
        end else if (filt_cnt_ff >= 16'(PIN_FILT_CYC - 1)) begin
            nxt_pin_req = 1'b1;
        end else begin
            nxt_filt_cnt = filt_cnt_ff + 16'h0001;
        end
        nxt_hv_prev = s_hv;
        nxt_hv_req = s_hv ^ hv_prev_ff;
        nxt_wdt_prev = s_wdt;
        nxt_wdt_dly = wdt_dly_ff;
        // Delay counters model the source-to-reset latency
        if (wdt_enable && s_wdt && !wdt_prev_ff) begin
            nxt_wdt_dly = RSTC_SRC_DELAY_CNT;
        end else if (wdt_dly_ff != 5'h00) begin
            nxt_wdt_dly = wdt_dly_ff - 5'h01;
        end
        nxt_sw_dly = sw_dly_ff;
        if (sw_fire) begin
            nxt_sw_dly = RSTC_SRC_DELAY_CNT;
        end else if (sw_dly_ff != 5'h00) begin
            nxt_sw_dly = sw_dly_ff - 5'h01;
        end
    end

    assign wdt_req = (wdt_dly_ff == 5'h01);
    assign sw_req = (sw_dly_ff == 5'h01);
    assign bod_req = bod_enable && s_bod;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            filt_cnt_ff <= 16'h0000;
            pin_req_ff <= 1'b0;
            hv_prev_ff <= 1'b0;
            hv_req_ff <= 1'b0;
            wdt_prev_ff <= 1'b0;
            wdt_dly_ff <= 5'h00;
            sw_dly_ff <= 5'h00;
        end else begin
            filt_cnt_ff <= nxt_filt_cnt;
            pin_req_ff <= nxt_pin_req;
            hv_prev_ff <= nxt_hv_prev;
            hv_req_ff <= nxt_hv_req;
            wdt_prev_ff <= nxt_wdt_prev;
            wdt_dly_ff <= nxt_wdt_dly;
            sw_dly_ff <= nxt_sw_dly;
        end
    end

    // Any active source; debug input comes only from the debug pin
    logic supply_act, user_act, any_act;
    assign supply_act = s_por || bod_req;
    assign user_act = pin_req_ff || wdt_req || sw_req || s_dbg || hv_req_ff;
    assign any_act = supply_act || user_act;

    // Sequencer and domain resets
    rstc_state_t state_ff, nxt_state;
    logic [31:0] seq_cnt_ff, nxt_seq_cnt;
    logic supply_cause_ff, nxt_supply_cause;
    logic hv_cause_ff, nxt_hv_cause;
    logic nxt_sys_rst_b, nxt_bod_cfg_rst_b, nxt_dbg_rst_b, nxt_fuse_reload, nxt_crc_start;
    logic [31:0] startup_cyc;
    assign startup_cyc = 32'(startup_delay_select) * 32'(STARTUP_UNIT_CYC);

    always_comb begin
        nxt_state = state_ff;
        nxt_seq_cnt = seq_cnt_ff;
        nxt_supply_cause = supply_cause_ff;
        nxt_hv_cause = hv_cause_ff;
        nxt_crc_start = 1'b0;
        case (state_ff)
            RSTC_HOLD: begin
                nxt_seq_cnt = 32'h0000_0000;
                if (!any_act) begin
                    nxt_state = RSTC_INIT;
                end
            end
            RSTC_INIT: begin
                nxt_seq_cnt = seq_cnt_ff + 32'h0000_0001;
                // Supply causes add the fuse start-up delay
                if (seq_cnt_ff + 32'h0000_0001 >= 32'(INIT_CYC) + (supply_cause_ff ? startup_cyc : 32'h0)) begin
                    if (boot_crc_scan_select) begin
                        nxt_state = RSTC_SCAN;
                        nxt_crc_start = 1'b1;
                    end else begin
                        nxt_state = RSTC_RUN;
                    end
                end
            end
            RSTC_SCAN: begin
                // Done may still stand from an earlier scan while the start
                // pulse is out; trust it only from the next cycle on
                if (crc_scan_done && !crc_scan_start_ff) begin
                    nxt_state = RSTC_RUN;
                end
            end
            RSTC_RUN: begin
                nxt_supply_cause = 1'b0;
                nxt_hv_cause = 1'b0;
            end
            default: nxt_state = RSTC_HOLD;
        endcase
        // A new source restarts the hold at once from any state
        if (any_act) begin
            nxt_state = RSTC_HOLD;
            nxt_crc_start = 1'b0;
            if (supply_act) begin
                nxt_supply_cause = 1'b1;
            end
            if (hv_req_ff) begin
                nxt_hv_cause = 1'b1;
            end
        end
        nxt_sys_rst_b = (nxt_state == RSTC_RUN);
        nxt_fuse_reload = (nxt_state == RSTC_HOLD);
        nxt_bod_cfg_rst_b = !(nxt_state == RSTC_HOLD && nxt_supply_cause);
        nxt_dbg_rst_b = !(nxt_state == RSTC_HOLD && (nxt_supply_cause || nxt_hv_cause));
    end

    // Synchronous release; the reset input forces outputs to reset value
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_ff <= RSTC_HOLD;
            seq_cnt_ff <= 32'h0000_0000;
            supply_cause_ff <= 1'b1;
            hv_cause_ff <= 1'b0;
            sys_rst_b_ff <= 1'b0;
            bod_cfg_rst_b_ff <= 1'b0;
            debug_port_rst_b_ff <= 1'b0;
            fuse_reload_ff <= 1'b1;
            crc_scan_start_ff <= 1'b0;
            pc_reset_value_ff <= RSTC_PC_START;
        end else begin
            state_ff <= nxt_state;
            seq_cnt_ff <= nxt_seq_cnt;
            supply_cause_ff <= nxt_supply_cause;
            hv_cause_ff <= nxt_hv_cause;
            sys_rst_b_ff <= nxt_sys_rst_b;
            bod_cfg_rst_b_ff <= nxt_bod_cfg_rst_b;
            debug_port_rst_b_ff <= nxt_dbg_rst_b;
            fuse_reload_ff <= nxt_fuse_reload;
            crc_scan_start_ff <= nxt_crc_start;
            pc_reset_value_ff <= RSTC_PC_START;
        end
    end

    // APB registers: cause flags, unlock window
    logic [5:0] reset_cause_flags_ff, nxt_cause;
    logic [2:0] unlock_cnt_ff, nxt_unlock_cnt;
    logic [31:0] nxt_prdata;
    logic nxt_pready, nxt_pslverr;
    logic acc, wr, mapped;
    assign acc = psel && penable && !pready;
    // Writes commit on the completing edge, when pready is seen high
    assign wr = psel && penable && pready && pwrite;
    assign mapped = paddr == RSTC_ADDR_CAUSE || paddr == RSTC_ADDR_SWREQ || paddr == RSTC_ADDR_UNLOCK
        || (paddr == RSTC_ADDR_STATUS && !pwrite);
    assign sw_fire = wr && paddr == RSTC_ADDR_SWREQ && unlock_cnt_ff != 3'h0 && pwdata[RSTC_TRIG_BIT];

    always_comb begin
        nxt_cause = reset_cause_flags_ff;
        nxt_unlock_cnt = unlock_cnt_ff;
        nxt_prdata = 32'h0000_0000;
        nxt_pready = acc;
        nxt_pslverr = 1'b0;
        if (cpu_insn_retire && unlock_cnt_ff != 3'h0) begin
            nxt_unlock_cnt = unlock_cnt_ff - 3'h1;
        end
        // Write-one clears first so a same-cycle cause wins
        if (wr && paddr == RSTC_ADDR_CAUSE) begin
            nxt_cause = reset_cause_flags_ff & ~pwdata[5:0];
        end else if (wr && paddr == RSTC_ADDR_UNLOCK) begin
            nxt_unlock_cnt = (pwdata[7:0] == RSTC_IO_KEY) ? RSTC_UNLOCK_WIN_CNT : 3'h0;
        end else if (wr && paddr == RSTC_ADDR_SWREQ) begin
            nxt_unlock_cnt = 3'h0;
        end else if (acc && !pwrite && paddr == RSTC_ADDR_CAUSE) begin
            nxt_prdata = {26'h0, reset_cause_flags_ff};
        end else if (acc && !pwrite && paddr == RSTC_ADDR_SWREQ) begin
            nxt_prdata = 32'h0000_0000;
        end else if (acc && !pwrite && paddr == RSTC_ADDR_UNLOCK) begin
            nxt_prdata = {29'h0, unlock_cnt_ff};
        end else if (acc && !pwrite && paddr == RSTC_ADDR_STATUS) begin
            nxt_prdata = {28'h0, state_ff};
        end else if (acc && !mapped) begin
            nxt_pslverr = 1'b1;
        end
        // Priority among causes: power-on clears the rest, brown-out all but power-on
        if (s_por) begin
            nxt_cause = 6'h01;
        end else if (bod_req) begin
            nxt_cause = (reset_cause_flags_ff & 6'h01) | 6'h02;
        end else begin
            if (pin_req_ff) nxt_cause[RSTC_F_EXT] = 1'b1;
            if (wdt_req) nxt_cause[RSTC_F_WDT] = 1'b1;
            if (sw_req) nxt_cause[RSTC_F_SW] = 1'b1;
            if (s_dbg || hv_req_ff) nxt_cause[RSTC_F_DBG] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reset_cause_flags_ff <= RSTC_CAUSE_RST[5:0];
            unlock_cnt_ff <= 3'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            reset_cause_flags_ff <= nxt_cause;
            unlock_cnt_ff <= nxt_unlock_cnt;
            prdata <= nxt_prdata;
            pready <= nxt_pready;
            pslverr <= nxt_pslverr;
        end
    end

    sequence hold_seq;
        state_ff == RSTC_HOLD;
    endsequence
    sequence released_seq;
        state_ff == RSTC_INIT;
    endsequence

    por_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) s_por |=> hold_seq)
        else $error("power-on did not hold");
    release_a: assert property (@(posedge mclk) disable iff (!rst_b) hold_seq ##1 released_seq |-> !$past(any_act))
        else $error("released while source active");
    sysrst_a: assert property (@(posedge mclk) disable iff (!rst_b) state_ff != RSTC_RUN |-> !sys_rst_b_ff)
        else $error("system out of reset early");
    swr_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(pready) && !$past(pwrite) && $past(paddr) == RSTC_ADDR_SWREQ |-> prdata == 32'h0)
        else $error("trigger reads nonzero");
    // A loaded software delay must come from an unlocked write
    lock_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sw_dly_ff == RSTC_SRC_DELAY_CNT |-> $past(wr) && $past(unlock_cnt_ff) != 3'h0)
        else $error("locked write fired");
    sw_delay_a: assert property (@(posedge mclk) disable iff (!rst_b) sw_fire |-> ##18 sw_req)
        else $error("software reset delay wrong");
    pin_off_a: assert property (@(posedge mclk) disable iff (!rst_b) !reset_pin_enable_fuse |=> !pin_req_ff)
        else $error("pin reset while disabled");
    por_flag_a: assert property (@(posedge mclk) disable iff (!rst_b) s_por |=> reset_cause_flags_ff == 6'h01)
        else $error("power-on flags wrong");
    bod_cfg_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !bod_cfg_rst_b_ff |-> supply_cause_ff)
        else $error("user reset touched brown-out config");
    pc_a: assert property (@(posedge mclk) disable iff (!rst_b) $rose(sys_rst_b_ff) |-> pc_reset_value_ff == 32'h0)
        else $error("start address not zero");

endmodule // rstc_reset_controller

// *** shared/rstc_pkg.sv ***
/*
 * Constants for the reset controller: register map, cause flag layout,
 * unlock key, timing counts and sequencer states.
 * Assumes a 125 MHz mclk and 32-bit APB access, one register per word.
 */
package rstc_pkg;
    // Printed offsets are not all multiples of four: offsets are indices
    localparam logic [7:0] RSTC_IDX_CAUSE = 8'h00;
    localparam logic [7:0] RSTC_IDX_SWREQ = 8'h01;
    localparam logic [7:0] RSTC_IDX_UNLOCK = 8'h02;
    localparam logic [7:0] RSTC_IDX_STATUS = 8'h03;
    localparam logic [11:0] RSTC_ADDR_CAUSE = {2'h0, RSTC_IDX_CAUSE, 2'h0};
    localparam logic [11:0] RSTC_ADDR_SWREQ = {2'h0, RSTC_IDX_SWREQ, 2'h0};
    localparam logic [11:0] RSTC_ADDR_UNLOCK = {2'h0, RSTC_IDX_UNLOCK, 2'h0};
    localparam logic [11:0] RSTC_ADDR_STATUS = {2'h0, RSTC_IDX_STATUS, 2'h0};
    // Cause flag bit positions
    localparam int RSTC_F_POR = 0;
    localparam int RSTC_F_BOR = 1;
    localparam int RSTC_F_EXT = 2;
    localparam int RSTC_F_WDT = 3;
    localparam int RSTC_F_SW = 4;
    localparam int RSTC_F_DBG = 5;
    localparam int RSTC_NFLAGS = 6;
    localparam int RSTC_TRIG_BIT = 0;
    // Unlock key value is arbitrary
    localparam logic [7:0] RSTC_IO_KEY = 8'h5a;
    localparam int RSTC_UNLOCK_WINDOW = 4;
    localparam logic [2:0] RSTC_UNLOCK_WIN_CNT = 3'(RSTC_UNLOCK_WINDOW);
    // Timing
    localparam int RSTC_CLK_MHZ = 125;
    localparam int RSTC_SRC_DELAY_NS = 150;
    localparam int RSTC_SRC_DELAY_CYC = (RSTC_SRC_DELAY_NS * RSTC_CLK_MHZ) / 1000;
    localparam logic [4:0] RSTC_SRC_DELAY_CNT = 5'(RSTC_SRC_DELAY_CYC);
    localparam int RSTC_PIN_FILT_NS = 2000;
    localparam int RSTC_PIN_FILT_CYC = (RSTC_PIN_FILT_NS * RSTC_CLK_MHZ + 999) / 1000;
    localparam int RSTC_INIT_CYC = 64;
    localparam logic [7:0] RSTC_CAUSE_RST = 8'h01;
    localparam logic [31:0] RSTC_PC_START = 32'h0000_0000;

    typedef enum logic [3:0] {
        RSTC_HOLD = 4'b0001,
        RSTC_INIT = 4'b0010,
        RSTC_SCAN = 4'b0100,
        RSTC_RUN = 4'b1000
    } rstc_state_t;
endpackage

// *** test/rstc_far_model.sv ***
/*
 * Far-side model: memory scanner and CPU retire pulses.
 * Assumes it shares mclk and rst_b with the reset controller.
 */
`timescale 1ns/10ps
module rstc_far_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sys_rst_b_ff,
    input wire logic crc_scan_start_ff,
    input wire logic slow,
    output logic crc_scan_done,
    output logic cpu_insn_retire
);
    logic [3:0] scan_cnt_ff, nxt_scan_cnt;
    logic done_ff, nxt_done;
    logic [1:0] ret_cnt_ff, nxt_ret_cnt;
    // Scan takes 2 or 12 cycles; done holds until the next start
    always_comb begin
        nxt_scan_cnt = scan_cnt_ff;
        nxt_done = done_ff;
        nxt_ret_cnt = ret_cnt_ff + 2'h1;
        if (crc_scan_start_ff) begin
            nxt_scan_cnt = slow ? 4'hc : 4'h2;
            nxt_done = 1'b0;
        end else if (scan_cnt_ff != 4'h0) begin
            nxt_scan_cnt = scan_cnt_ff - 4'h1;
            nxt_done = (scan_cnt_ff == 4'h1);
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scan_cnt_ff <= 4'h0;
            done_ff <= 1'b0;
            ret_cnt_ff <= 2'h0;
        end else begin
            scan_cnt_ff <= nxt_scan_cnt;
            done_ff <= nxt_done;
            ret_cnt_ff <= nxt_ret_cnt;
        end
    end
    assign crc_scan_done = done_ff;
    // One instruction every fourth cycle; a held core retires none
    assign cpu_insn_retire = sys_rst_b_ff && (ret_cnt_ff == 2'h3);
endmodule // rstc_far_model

// *** test/rstc_reset_controller_tb.sv ***
/*
 * Self-checking bench for the reset controller: APB register access,
 * every reset source, domain resets, cause flags and the unlock window.
 * Assumes small counts: filter 4, init 4, start-up unit 2 cycles.
 */
`timescale 1ns/10ps
module rstc_reset_controller_tb
    import rstc_pkg::*;
;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, por_low, bod_low, bod_enable, reset_pin;
    logic reset_pin_enable_fuse, hv_present, wdt_timeout, wdt_enable, program_debug_port_reset;
    logic boot_crc_scan_select, crc_scan_done, cpu_insn_retire, sys_rst_b_ff, bod_cfg_rst_b_ff;
    logic debug_port_rst_b_ff, fuse_reload_ff, crc_scan_start_ff, scan_slow, bod_lo, dbg_lo, fz, sc, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pc_reset_value_ff, rd, exp_cause, mask;
    logic [2:0] startup_delay_select;
    int fails, compares, cyc, t0, low_at, n;
    int order[8] = '{3, 4, 2, 5, 6, 6, 1, 0};
    rstc_reset_controller #(.PIN_FILT_CYC(4), .INIT_CYC(4), .STARTUP_UNIT_CYC(2)) rstc_reset_controller_inst (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_low(por_low),
        .bod_low(bod_low), .bod_enable(bod_enable), .reset_pin(reset_pin), .hv_present(hv_present),
        .reset_pin_enable_fuse(reset_pin_enable_fuse), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable),
        .program_debug_port_reset(program_debug_port_reset), .startup_delay_select(startup_delay_select),
        .boot_crc_scan_select(boot_crc_scan_select), .crc_scan_done(crc_scan_done),
        .cpu_insn_retire(cpu_insn_retire), .sys_rst_b_ff(sys_rst_b_ff), .bod_cfg_rst_b_ff(bod_cfg_rst_b_ff),
        .debug_port_rst_b_ff(debug_port_rst_b_ff), .fuse_reload_ff(fuse_reload_ff),
        .crc_scan_start_ff(crc_scan_start_ff), .pc_reset_value_ff(pc_reset_value_ff));
    rstc_far_model rstc_far_model_inst (.mclk(mclk), .rst_b(rst_b), .sys_rst_b_ff(sys_rst_b_ff),
        .crc_scan_start_ff(crc_scan_start_ff), .slow(scan_slow), .crc_scan_done(crc_scan_done),
        .cpu_insn_retire(cpu_insn_retire));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic conclude();
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cycle count, hang limit and what each reset episode touched
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            conclude();
        end else if (sys_rst_b_ff !== 1'b1) begin
            if (low_at < 0) low_at = cyc;
            bod_lo |= (bod_cfg_rst_b_ff === 1'b0);
            dbg_lo |= (debug_port_rst_b_ff === 1'b0);
            fz |= (fuse_reload_ff === 1'b1);
            sc |= (crc_scan_start_ff === 1'b1);
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        if (n >= 40) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic arm();
        low_at = -1;
        {bod_lo, dbg_lo, fz, sc} = 4'h0;
        t0 = cyc;
    endtask
    function automatic logic [31:0] next_cause(input logic [31:0] prev, input int k);
        if (k == 0) return 32'h1;
        if (k == 1) return (prev & 32'h1) | 32'h2;
        return prev | (32'h1 << (k == 6 ? 5 : k));
    endfunction
    // Wait for release, then check domains, timing and cause flags
    task automatic settle(input int k);
        int i;
        // Delayed sources may not have fired yet: wait for the drop first
        i = 0;
        while (low_at < 0 && i < 60) begin
            @(posedge mclk);
            i++;
        end
        i = 0;
        while (sys_rst_b_ff !== 1'b1 && i < 800) begin
            @(posedge mclk);
            i++;
        end
        chk1(low_at >= 0 && low_at - t0 <= (k == 0 ? 6 : 34), 1'b1);
        chk1(low_at - t0 >= ((k == 3 || k == 4) ? 14 : 0), 1'b1);
        chk1(bod_lo, k < 2);
        chk1(dbg_lo, k < 2 || k == 6);
        chk1(fz, 1'b1);
        chk1(sc, boot_crc_scan_select);
        chk32(pc_reset_value_ff, 32'h0);
        exp_cause = next_cause(exp_cause, k);
        apb(1'b0, RSTC_ADDR_CAUSE, 32'h0);
        chk32(rd, exp_cause);
        apb(1'b0, RSTC_ADDR_STATUS, 32'h0);
        chk32(rd, 32'h8);
        mask = $urandom;
        exp_cause &= ~mask;
        apb(1'b1, RSTC_ADDR_CAUSE, mask);
        apb(1'b0, RSTC_ADDR_CAUSE, 32'h0);
        chk32(rd, exp_cause);
        boot_crc_scan_select <= 1'($urandom);
        scan_slow <= 1'($urandom);
    endtask
    // Raise one source, hold it where it is a level, then release
    task automatic fire(input int k);
        arm();
        case (k)
            0: por_low <= 1'b1;
            1: bod_low <= 1'b1;
            2: reset_pin <= 1'b0;
            3: wdt_timeout <= 1'b1;
            5: program_debug_port_reset <= 1'b1;
            6: hv_present <= ~hv_present;
            default: begin
                apb(1'b1, RSTC_ADDR_UNLOCK, {24'h0, RSTC_IO_KEY});
                t0 = cyc;
                apb(1'b1, RSTC_ADDR_SWREQ, 32'h1);
            end
        endcase
        repeat (12 + $urandom % 20) @(posedge mclk);
        if (k < 3) chk1(sys_rst_b_ff, 1'b0);
        {por_low, bod_low, wdt_timeout, program_debug_port_reset} <= 4'h0;
        reset_pin <= 1'b1;
        settle(k);
    endtask
    initial begin
        void'($urandom(32'h555e));
        {rst_b, psel, penable, pwrite, por_low, bod_low, bod_enable, hv_present} = 8'h0;
        {wdt_timeout, wdt_enable, program_debug_port_reset, reset_pin_enable_fuse} = 4'h0;
        reset_pin = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        startup_delay_select = 3'($urandom);
        boot_crc_scan_select = 1'($urandom);
        scan_slow = 1'($urandom);
        exp_cause = 32'h0;
        arm();
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        settle(0);
        // Unmapped places refuse; trigger bit reads zero
        apb(1'b0, 12'h010, 32'h0);
        chk1(err, 1'b1);
        chk32(rd, 32'h0);
        apb(1'b1, 12'h3fc, $urandom);
        chk1(err, 1'b1);
        apb(1'b0, RSTC_ADDR_SWREQ, 32'h0);
        chk32(rd, 32'h0);
        // Disabled sources, short pin pulse and unlock misuse stay quiet
        arm();
        wdt_timeout <= 1'b1;
        reset_pin <= 1'b0;
        bod_low <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        repeat (30) @(posedge mclk);
        {reset_pin, bod_low, reset_pin_enable_fuse} <= 3'b101;
        repeat (4) @(posedge mclk);
        reset_pin <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_pin <= 1'b1;
        apb(1'b1, RSTC_ADDR_UNLOCK, {24'h0, RSTC_IO_KEY ^ (8'($urandom) | 8'h01)});
        apb(1'b1, RSTC_ADDR_SWREQ, 32'h1);
        apb(1'b1, RSTC_ADDR_UNLOCK, {24'h0, RSTC_IO_KEY});
        repeat (24) @(posedge mclk);
        apb(1'b1, RSTC_ADDR_SWREQ, 32'h1);
        repeat (30) @(posedge mclk);
        chk1(low_at < 0, 1'b1);
        bod_enable <= 1'b1;
        wdt_enable <= 1'b1;
        for (int i = 0; i < 8; i++) fire(order[i]);
        repeat (5) fire($urandom % 7);
        conclude();
    end
endmodule // rstc_reset_controller_tb
